// [dv/ssf_host_model.sv]
// Host side register master for the status flag block
`timescale 1ns/100ps
module ssf_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'h0;
    rd    = 1'h0;
  end

  // One strobe cycle, write or read
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr    <= 1'h0;
    rd    <= 1'h0;
  endtask
endmodule

// [dv/ssf_status_regs_tb.sv]
// Self-checking bench of the sensor status flag registers
`timescale 1ns/100ps
module ssf_status_regs_tb;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, irq;
  logic       rd_seen = 1'h0;
  logic       orc = 1'h0, pn = 1'h0, tn = 1'h0, push = 1'h0, pop = 1'h0;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int         err_total = 0, compares = 0, seed = 73651, n, thr;

  always #2.5 clk = ~clk;

  ssf_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  ssf_status_regs uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .output_rate_cycle(orc), .press_new(pn), .temp_new(tn),
    .fifo_push(push), .fifo_pop(pop), .irq(irq));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic care);
    exp_q.push_back({care, exp});
    host.acc(a, 8'h00, 1'h0);
  endtask

  task automatic irq_is(input logic v);
    @(posedge clk);
    #1;
    check({7'h00, irq}, {7'h00, v});
  endtask

  task automatic ev(input logic p, input logic t, input logic pu, input logic po);
    @(posedge clk);
    orc  <= p | t;
    pn   <= p;
    tn   <= t;
    push <= pu;
    pop  <= po;
    @(posedge clk);
    {orc, pn, tn, push, pop} <= 5'h00;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen) begin
      e = exp_q.pop_front();
      if (e[8]) check(rdata, e[7:0]);
    end
  end

  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd_chk(8'h26, 8'h00, 1'h1);
    rd_chk(8'h27, 8'h00, 1'h1);
    rd_chk(8'h40, 8'h00, 1'h1);
    host.acc(8'h27, 8'hFF, 1'h1);
    rd_chk(8'h27, 8'h00, 1'h1);
    host.acc(8'h31, 8'h01, 1'h1);
    ev(1'h1, 1'h0, 1'h0, 1'h0);
    rd_chk(8'h27, 8'h01, 1'h1);
    irq_is(1'h1);
    host.acc(8'h30, 8'h01, 1'h1);
    irq_is(1'h0);
    ev(1'h1, 1'h1, 1'h0, 1'h0);
    rd_chk(8'h27, 8'h13, 1'h1);
    ev(1'h0, 1'h1, 1'h0, 1'h0);
    rd_chk(8'h27, 8'h33, 1'h1);
    rd_chk(8'h2A, 8'h00, 1'h0);
    rd_chk(8'h27, 8'h22, 1'h1);
    rd_chk(8'h2C, 8'h00, 1'h0);
    rd_chk(8'h27, 8'h00, 1'h1);
    host.acc(8'h31, 8'h00, 1'h1);
    irq_is(1'h0);
    host.acc(8'h31, 8'h01, 1'h1);
    irq_is(1'h1);
    host.acc(8'h30, 8'hFF, 1'h1);
    irq_is(1'h0);
    rd_chk(8'h30, 8'h00, 1'h1);
    rd_chk(8'h31, 8'h01, 1'h1);
    thr = 1 + {$random(seed)} % 31;
    n = {$random(seed)} % 32;
    host.acc(8'h32, 8'(thr), 1'h1);
    rd_chk(8'h32, 8'(thr), 1'h1);
    repeat (n) ev(1'h0, 1'h0, 1'h1, 1'h0);
    rd_chk(8'h26, {n >= thr, 1'h0, 6'(n)}, 1'h1);
    repeat (32 - n) ev(1'h0, 1'h0, 1'h1, 1'h0);
    rd_chk(8'h26, 8'hA0, 1'h1);
    ev(1'h0, 1'h0, 1'h1, 1'h0);
    rd_chk(8'h26, 8'hE0, 1'h1);
    ev(1'h0, 1'h0, 1'h0, 1'h1);
    rd_chk(8'h26, 8'h9F, 1'h1);
    ev(1'h0, 1'h0, 1'h1, 1'h1);
    rd_chk(8'h26, 8'h9F, 1'h1);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_chk(8'h26, 8'h00, 1'h1);
    rd_chk(8'h32, 8'h00, 1'h1);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule

// [hdl/ssf_fifo_level.sv]
// Fill level tracker of the sample FIFO with watermark and overwrite flags
`timescale 1ns/100ps
`include "ssf_params.svh"
module ssf_fifo_level (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Sample events
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic [5:0] threshold,
  // Status byte
  output logic [7:0]      status
);
  typedef struct packed {
    logic [5:0] count;
    logic       ovr;
    logic [7:0] status;
  } ssf_lvl_state_t;

  ssf_lvl_state_t s_q;
  ssf_lvl_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (push && !pop) begin
      if (s_q.count == `SSF_FIFO_FULL) begin
        s_d.ovr = 1'b1;
      end else begin
        s_d.count = s_q.count + 6'h01;
      end
    end else if (pop && !push && s_q.count != 6'h00) begin
      s_d.count = s_q.count - 6'h01;
      s_d.ovr   = 1'b0;
    end
    s_d.status[5:0] = s_d.count;
    s_d.status[`SSF_BIT_OVERWRITE] = s_d.ovr && s_d.count == `SSF_FIFO_FULL;
    // Empty FIFO never shows the watermark
    s_d.status[`SSF_BIT_WATERMARK] = (s_d.count != 6'h00 && s_d.count >= threshold)
                                     || s_d.ovr;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;

  a_ovr_full: assert property (@(posedge clk) disable iff (rst)
    status[`SSF_BIT_OVERWRITE]
    |-> status[5:0] == 6'h20 && status[7])
    else $error("overwrite flag without full count");
  a_count_max: assert property (@(posedge clk) disable iff (rst)
    status[5:0] <= 6'h20)
    else $error("unread count above full");
endmodule

// [hdl/ssf_params.svh]
// Offsets, field positions, reset values and sizes for the sensor status flags
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH
`define SSF_ADDR_FIFO_STAT   8'h26
`define SSF_ADDR_READY_STAT  8'h27
`define SSF_ADDR_PRESS_HIGH  8'h2A
`define SSF_ADDR_TEMP_HIGH   8'h2C
`define SSF_ADDR_IRQ_STAT    8'h30
`define SSF_ADDR_IRQ_MASK    8'h31
`define SSF_ADDR_FIFO_THR    8'h32
`define SSF_BIT_WATERMARK    7
`define SSF_BIT_OVERWRITE    6
`define SSF_BIT_TEMP_OVR     5
`define SSF_BIT_PRESS_OVR    4
`define SSF_BIT_TEMP_NEW     1
`define SSF_BIT_PRESS_NEW    0
`define SSF_FIFO_FULL        6'h20
`define SSF_RESET_BYTE       8'h00
`endif

// [hdl/ssf_pkg.sv]
// Types shared by the sensor status flag block
package ssf_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssf_bus_req_t;

  typedef struct packed {
    logic       press_new;
    logic       temp_new;
    logic       push;
    logic       pop;
  } ssf_event_t;
endpackage

// [hdl/ssf_status_regs.sv]
// Function
// - watermark flag set when count reaches threshold
// - overwrite flag only when full and overwritten
// - bits 5..0 hold unread sample count
// - overwrite shows both flags and full count
// - new flags set only on a rate cycle with a new sample
// - pressure overrun on unread sample; cleared by read
// - temperature overrun on unread sample
// - temperature new flag; cleared by high read
// - pressure new flag; cleared by high read
`timescale 1ns/100ps
`include "ssf_params.svh"
module ssf_status_regs (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // Sample events from the conversion logic
  input  wire logic       output_rate_cycle,
  input  wire logic       press_new,
  input  wire logic       temp_new,
  input  wire logic       fifo_push,
  input  wire logic       fifo_pop,
  // Interrupt
  output logic            irq
);
  typedef struct packed {
    logic [7:0] ready;
    logic [7:0] istat;
    logic [7:0] imask;
    logic [5:0] thr;
    logic [7:0] rdata;
  } ssf_state_t;

  ssf_state_t       s_q;
  ssf_state_t       s_d;
  ssf_pkg::ssf_bus_req_t req;
  ssf_pkg::ssf_event_t   evt;
  logic [7:0]       fifo_status;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  // Sample events of one rate cycle
  assign evt = '{press_new: press_new, temp_new: temp_new, push: fifo_push, pop: fifo_pop};

  ssf_fifo_level u_level (
    .clk       (clk),
    .rst       (rst),
    .push      (evt.push),
    .pop       (evt.pop),
    .threshold (s_q.thr),
    .status    (fifo_status)
  );

  function automatic logic [7:0] ssf_read_mux(input ssf_state_t s, input logic [7:0] a,
                                              input logic [7:0] f);
    case (a)
      `SSF_ADDR_FIFO_STAT:  ssf_read_mux = f;
      `SSF_ADDR_READY_STAT: ssf_read_mux = s.ready;
      `SSF_ADDR_IRQ_STAT:   ssf_read_mux = s.istat;
      `SSF_ADDR_IRQ_MASK:   ssf_read_mux = s.imask;
      `SSF_ADDR_FIFO_THR:   ssf_read_mux = {2'b00, s.thr};
      default:              ssf_read_mux = `SSF_RESET_BYTE;
    endcase
  endfunction

  // Strobe hitting one address
  function automatic logic ssf_hit(input logic strobe, input logic [7:0] a,
                                   input logic [7:0] target);
    ssf_hit = strobe && a == target;
  endfunction

  logic p_clr;
  logic t_clr;
  logic p_evt;
  logic t_evt;
  logic [7:0] ev_bits;

  assign p_clr = ssf_hit(req.rd, req.addr, `SSF_ADDR_PRESS_HIGH);
  assign t_clr = ssf_hit(req.rd, req.addr, `SSF_ADDR_TEMP_HIGH);
  assign p_evt = output_rate_cycle && evt.press_new;
  assign t_evt = output_rate_cycle && evt.temp_new;

  always_comb begin
    s_d = s_q;
    // Reads clear first, new samples override
    if (p_clr) begin
      s_d.ready[`SSF_BIT_PRESS_NEW] = 1'b0;
      s_d.ready[`SSF_BIT_PRESS_OVR] = 1'b0;
    end
    if (t_clr) begin
      s_d.ready[`SSF_BIT_TEMP_NEW] = 1'b0;
      s_d.ready[`SSF_BIT_TEMP_OVR] = 1'b0;
    end
    if (p_evt) begin
      if (s_q.ready[`SSF_BIT_PRESS_NEW] && !p_clr) begin
        s_d.ready[`SSF_BIT_PRESS_OVR] = 1'b1;
      end
      s_d.ready[`SSF_BIT_PRESS_NEW] = 1'b1;
    end
    if (t_evt) begin
      if (s_q.ready[`SSF_BIT_TEMP_NEW] && !t_clr) begin
        s_d.ready[`SSF_BIT_TEMP_OVR] = 1'b1;
      end
      s_d.ready[`SSF_BIT_TEMP_NEW] = 1'b1;
    end
    s_d.ready[7:6] = 2'b00;
    s_d.ready[3:2] = 2'b00;
    // Interrupt status, write one clears, set wins
    if (ssf_hit(req.wr, req.addr, `SSF_ADDR_IRQ_STAT)) begin
      s_d.istat = s_q.istat & ~req.wdata;
    end
    if (ssf_hit(req.wr, req.addr, `SSF_ADDR_IRQ_MASK)) begin
      s_d.imask = req.wdata;
    end
    if (ssf_hit(req.wr, req.addr, `SSF_ADDR_FIFO_THR)) begin
      s_d.thr = req.wdata[5:0];
    end
    ev_bits = '0;
    ev_bits[`SSF_BIT_PRESS_NEW] = p_evt;
    ev_bits[`SSF_BIT_TEMP_NEW]  = t_evt;
    ev_bits[`SSF_BIT_PRESS_OVR] = s_d.ready[`SSF_BIT_PRESS_OVR] & ~s_q.ready[`SSF_BIT_PRESS_OVR];
    ev_bits[`SSF_BIT_TEMP_OVR]  = s_d.ready[`SSF_BIT_TEMP_OVR] & ~s_q.ready[`SSF_BIT_TEMP_OVR];
    ev_bits[`SSF_BIT_WATERMARK] = fifo_status[`SSF_BIT_WATERMARK];
    ev_bits[`SSF_BIT_OVERWRITE] = fifo_status[`SSF_BIT_OVERWRITE];
    s_d.istat = s_d.istat | ev_bits;
    s_d.rdata = req.rd ? ssf_read_mux(s_q, req.addr, fifo_status) : `SSF_RESET_BYTE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq   = |(s_q.istat & s_q.imask);

  // Status flag checks
  a_press_new_set: assert property (@(posedge clk) disable iff (rst)
    output_rate_cycle && press_new
    |=> s_q.ready[0])
    else $error("pressure new flag not set");

  a_temp_new_set: assert property (@(posedge clk) disable iff (rst)
    output_rate_cycle && temp_new
    |=> s_q.ready[1])
    else $error("temperature new flag not set");

  a_press_ovr_set: assert property (@(posedge clk) disable iff (rst)
    output_rate_cycle && press_new && s_q.ready[0] && !p_clr
    |=> s_q.ready[4])
    else $error("pressure overrun not set");

  a_temp_ovr_set: assert property (@(posedge clk) disable iff (rst)
    output_rate_cycle && temp_new && s_q.ready[1] && !t_clr
    |=> s_q.ready[5])
    else $error("temperature overrun not set");

  a_press_read_clr: assert property (@(posedge clk) disable iff (rst)
    p_clr && !p_evt
    |=> !s_q.ready[0] && !s_q.ready[4])
    else $error("pressure flags not cleared by read");

  a_temp_read_clr: assert property (@(posedge clk) disable iff (rst)
    t_clr && !t_evt
    |=> !s_q.ready[1] && !s_q.ready[5])
    else $error("temperature flags not cleared by read");

  a_press_both: assert property (@(posedge clk) disable iff (rst)
    p_evt && p_clr
    |=> s_q.ready[0] && !s_q.ready[4])
    else $error("pressure sample and read coincide wrongly");

  a_temp_both: assert property (@(posedge clk) disable iff (rst)
    t_evt && t_clr
    |=> s_q.ready[1] && !s_q.ready[5])
    else $error("temperature sample and read coincide wrongly");

  a_press_new_hold: assert property (@(posedge clk) disable iff (rst)
    s_q.ready[0] && !p_clr
    |=> s_q.ready[0])
    else $error("pressure new flag lost without read");

  a_temp_new_hold: assert property (@(posedge clk) disable iff (rst)
    s_q.ready[1] && !t_clr
    |=> s_q.ready[1])
    else $error("temperature new flag lost without read");

  a_press_ovr_hold: assert property (@(posedge clk) disable iff (rst)
    s_q.ready[4] && !p_clr
    |=> s_q.ready[4])
    else $error("pressure overrun lost without read");

  a_temp_ovr_hold: assert property (@(posedge clk) disable iff (rst)
    s_q.ready[5] && !t_clr
    |=> s_q.ready[5])
    else $error("temperature overrun lost without read");

  a_press_ovr_cause: assert property (@(posedge clk) disable iff (rst)
    !s_q.ready[4] && !(p_evt && s_q.ready[0] && !p_clr)
    |=> !s_q.ready[4])
    else $error("pressure overrun set without cause");

  a_temp_ovr_cause: assert property (@(posedge clk) disable iff (rst)
    !s_q.ready[5] && !(t_evt && s_q.ready[1] && !t_clr)
    |=> !s_q.ready[5])
    else $error("temperature overrun set without cause");

  a_no_spont_new: assert property (@(posedge clk) disable iff (rst)
    !s_q.ready[0] && !p_evt
    |=> !s_q.ready[0])
    else $error("pressure flag set without rate cycle");

  a_temp_no_spont: assert property (@(posedge clk) disable iff (rst)
    !s_q.ready[1] && !t_evt
    |=> !s_q.ready[1])
    else $error("temperature flag set without rate cycle");

  a_ready_quiet: assert property (@(posedge clk) disable iff (rst)
    !p_evt && !t_evt && !p_clr && !t_clr
    |=> $stable(s_q.ready))
    else $error("status changed without event or read");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    rd && addr == 8'h27
    |=> rdata[7:6] == 2'b00 && rdata[3:2] == 2'b00)
    else $error("reserved status bits not zero");

  // Read path checks
  a_ready_readback: assert property (@(posedge clk) disable iff (rst)
    rd && addr == 8'h27
    |=> rdata == $past(s_q.ready))
    else $error("status readback wrong");

  a_fifo_readback: assert property (@(posedge clk) disable iff (rst)
    rd && addr == 8'h26
    |=> rdata == $past(fifo_status))
    else $error("fifo status readback wrong");

  a_istat_readback: assert property (@(posedge clk) disable iff (rst)
    rd && addr == 8'h30
    |=> rdata == $past(s_q.istat))
    else $error("interrupt status readback wrong");

  a_mask_readback: assert property (@(posedge clk) disable iff (rst)
    rd && addr == 8'h31
    |=> rdata == $past(s_q.imask))
    else $error("interrupt mask readback wrong");

  a_thr_readback: assert property (@(posedge clk) disable iff (rst)
    rd && addr == 8'h32
    |=> rdata == {2'b00, $past(s_q.thr)})
    else $error("threshold readback wrong");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    rd && !(addr inside {8'h26, 8'h27, 8'h30, 8'h31, 8'h32})
    |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd
    |=> rdata == 8'h00)
    else $error("read data without read strobe");

  // FIFO flag checks
  a_watermark_level: assert property (@(posedge clk) disable iff (rst)
    fifo_status[5:0] >= s_q.thr && fifo_status[5:0] != 6'h00 && $stable(s_q.thr)
    |-> fifo_status[7])
    else $error("watermark flag missing");

  a_watermark_clear: assert property (@(posedge clk) disable iff (rst)
    fifo_status[5:0] < s_q.thr && !fifo_status[6] && $stable(s_q.thr)
    |-> !fifo_status[7])
    else $error("watermark flag below threshold");

  a_empty_no_mark: assert property (@(posedge clk) disable iff (rst)
    fifo_status[5:0] == 6'h00
    |-> !fifo_status[7])
    else $error("watermark flag on empty fifo");

  // Interrupt and threshold write checks
  a_istat_press_set: assert property (@(posedge clk) disable iff (rst)
    p_evt
    |=> s_q.istat[0])
    else $error("pressure event not latched");

  a_istat_press_ovr: assert property (@(posedge clk) disable iff (rst)
    p_evt && s_q.ready[0] && !p_clr && !s_q.ready[4]
    |=> s_q.istat[4])
    else $error("pressure overrun event not latched");

  a_istat_temp_ovr: assert property (@(posedge clk) disable iff (rst)
    t_evt && s_q.ready[1] && !t_clr && !s_q.ready[5]
    |=> s_q.istat[5])
    else $error("temperature overrun event not latched");

  a_istat_mark: assert property (@(posedge clk) disable iff (rst)
    fifo_status[7]
    |=> s_q.istat[7])
    else $error("watermark event not latched");

  a_istat_overwrite: assert property (@(posedge clk) disable iff (rst)
    fifo_status[6]
    |=> s_q.istat[6])
    else $error("overwrite event not latched");

  a_istat_sticky: assert property (@(posedge clk) disable iff (rst)
    s_q.istat[0] && !(wr && addr == 8'h30 && wdata[0])
    |=> s_q.istat[0])
    else $error("interrupt status lost without clear");

  a_istat_clear: assert property (@(posedge clk) disable iff (rst)
    wr && addr == 8'h30 && wdata[0] && !p_evt
    |=> !s_q.istat[0])
    else $error("interrupt status not cleared");

  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    wr && addr == 8'h31
    |=> s_q.imask == $past(wdata))
    else $error("interrupt mask write lost");

  a_thr_write: assert property (@(posedge clk) disable iff (rst)
    wr && addr == 8'h32
    |=> s_q.thr == $past(wdata[5:0]))
    else $error("threshold write lost");

  a_irq_follows: assert property (@(posedge clk) disable iff (rst)
    p_evt && s_q.imask[0] && !(wr && addr == 8'h31)
    |=> irq)
    else $error("interrupt not raised");

  a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
    !irq && ev_bits == 8'h00 && !(wr && addr == 8'h31)
    |=> !irq)
    else $error("interrupt raised without event");
endmodule
